/* File: design/sprs_pkg.sv */
// constants for the sensor power and reset sequencer (host side)
// assumes a 100 MHz system clock; times given in printed units
package sprs_pkg;
    localparam int unsigned CLK_MHZ        = 100;
    localparam int unsigned RAIL_STEP_US   = 100;
    localparam int unsigned HARD_RESET_MS  = 1;
    localparam int unsigned PLL_LOCK_MS    = 1;
    localparam int unsigned OFF_TIME_MS    = 100;
    localparam int unsigned INIT_EXTCLKS   = 150000;
    localparam int unsigned CLK_DIV        = 4;
    // edges from clock enable to first master clock rise
    localparam int unsigned MCLK_LAG       = 2;
    localparam int unsigned RAIL_STEP_CYC  = RAIL_STEP_US * CLK_MHZ;
    localparam int unsigned HARD_RESET_CYC = HARD_RESET_MS * 1000 * CLK_MHZ;
    localparam int unsigned PLL_LOCK_CYC   = PLL_LOCK_MS * 1000 * CLK_MHZ;
    localparam int unsigned OFF_TIME_CYC   = OFF_TIME_MS * 1000 * CLK_MHZ;
    localparam int unsigned INIT_CYC       = INIT_EXTCLKS * CLK_DIV;
    localparam int unsigned CNT_W          = 32;
    localparam int unsigned RAIL_W         = 5;
    localparam logic [15:0] CTRL_REG_ADDR  = 16'h301a;
    localparam int unsigned STREAM_BIT     = 2;
    // rail bits: 0 pll, 1 analog+pixel, 2 io, 3 core, 4 serial tx
    localparam logic [4:0]  RAILS_OFF      = 5'h00;
    localparam logic [4:0]  RAILS_ALL      = 5'h1f;
    typedef enum logic [3:0] {
        S_OFF      = 4'h0,
        S_RAILS_UP = 4'h1,
        S_RESET    = 4'h3,
        S_INIT     = 4'h2,
        S_CONFIG   = 4'h6,
        S_LOCK     = 4'h7,
        S_START    = 4'h5,
        S_STREAM   = 4'h4,
        S_STOP     = 4'hc,
        S_DRAIN    = 4'hd,
        S_RAILS_DN = 4'hf,
        S_COOL     = 4'he
    } sprs_state_t;
endpackage : sprs_pkg

/* File: design/sprs_sequencer.sv */
// host-side power, clock, reset and streaming sequencer for an image sensor
// assumes register writes go through an outside serial master (wr_req/wr_ack)
//
// Operation
// - pll rail first, analog/pixel after 100us
// - then io, core, serial tx, 100us apart
// - pll rail never rises after others
// - master clock only after rails stable
// - hard reset held at least 1ms
// - wait 150000 clocks before configuring
// - wait 1ms pll lock before streaming
// - streaming bit set last on power-up
// - clear streaming bit before removing power
// - rails off serial, core, io, analog, pll
// - stay unpowered at least 100ms
`timescale 1ns/1ps
`default_nettype none
module sprs_sequencer #(
    parameter int unsigned RAIL_STEP_CYC  = sprs_pkg::RAIL_STEP_CYC,
    parameter int unsigned HARD_RESET_CYC = sprs_pkg::HARD_RESET_CYC,
    parameter int unsigned INIT_CYC       = sprs_pkg::INIT_CYC,
    parameter int unsigned PLL_LOCK_CYC   = sprs_pkg::PLL_LOCK_CYC,
    parameter int unsigned OFF_TIME_CYC   = sprs_pkg::OFF_TIME_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        power_up,
    input  wire logic        power_down,
    input  wire logic        config_done,
    input  wire logic        standby_reached,
    input  wire logic        wr_ack,
    output logic [4:0]       rails_en,
    output logic             external_master_clock,
    output logic             sensor_reset_b,
    output logic             config_go,
    output logic             wr_req,
    output logic [15:0]      wr_addr,
    output logic [15:0]      wr_data,
    output logic             streaming,
    output logic             busy
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
        end
        else
        begin
            sync1_q <= {standby_reached, config_done};
            sync2_q <= sync1_q;
        end
    end
    wire cfg_done_s = sync2_q[0];
    wire stby_s     = sync2_q[1];

    // ------------------------------------------------------------
    // master clock divider
    // ------------------------------------------------------------
    logic [1:0] div_q;
    logic [1:0] div_d;
    logic       mclk_q;
    logic       mclk_d;
    logic       clk_run;
    always_comb
    begin
        div_d  = clk_run ? div_q + 2'h1 : 2'h0;
        mclk_d = clk_run ? div_q[1] : 1'b0;
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div_q  <= 2'h0;
            mclk_q <= 1'b0;
        end
        else
        begin
            div_q  <= div_d;
            mclk_q <= mclk_d;
        end
    end

    // ------------------------------------------------------------
    // sequence state machine
    // ------------------------------------------------------------
    sprs_pkg::sprs_state_t st_q;
    sprs_pkg::sprs_state_t st_d;
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic [4:0]  rails_q;
    logic [4:0]  rails_d;
    logic        rst_q;
    logic        rst_d;
    logic        go_q;
    logic        go_d;
    logic        wr_q;
    logic        wr_d;
    logic        wdat_q;
    logic        wdat_d;
    logic        strm_q;
    logic        strm_d;
    logic        clkon_q;
    logic        clkon_d;
    logic        busy_q;
    logic        busy_d;
    logic        cnt_zero;
    assign cnt_zero = (cnt_q == 32'h0);
    // clock stops on the same edge that drops the first rail
    assign clk_run  = clkon_d;

    always_comb
    begin
        st_d    = st_q;
        cnt_d   = cnt_zero ? cnt_q : cnt_q - 32'h1;
        rails_d = rails_q;
        rst_d   = rst_q;
        go_d    = 1'b0;
        wr_d    = wr_q;
        wdat_d  = wdat_q;
        strm_d  = strm_q;
        clkon_d = clkon_q;
        case (st_q)
            sprs_pkg::S_OFF:
            begin
                if (power_up)
                begin
                    rails_d = 5'h01;
                    cnt_d   = RAIL_STEP_CYC - 1;
                    st_d    = sprs_pkg::S_RAILS_UP;
                end
            end
            sprs_pkg::S_RAILS_UP:
            begin
                if (cnt_zero)
                begin
                    if (rails_q == sprs_pkg::RAILS_ALL)
                    begin
                        clkon_d = 1'b1;
                        // hold counted from the first master clock rise
                        cnt_d   = HARD_RESET_CYC - 1 + sprs_pkg::MCLK_LAG;
                        st_d    = sprs_pkg::S_RESET;
                    end
                    else
                    begin
                        rails_d = {rails_q[3:0], 1'b1};
                        cnt_d   = RAIL_STEP_CYC - 1;
                    end
                end
            end
            sprs_pkg::S_RESET:
            begin
                if (cnt_zero)
                begin
                    rst_d = 1'b1;
                    cnt_d = INIT_CYC - 1;
                    st_d  = sprs_pkg::S_INIT;
                end
            end
            sprs_pkg::S_INIT:
            begin
                if (cnt_zero)
                begin
                    go_d = 1'b1;
                    st_d = sprs_pkg::S_CONFIG;
                end
            end
            sprs_pkg::S_CONFIG:
            begin
                if (cfg_done_s)
                begin
                    cnt_d = PLL_LOCK_CYC - 1;
                    st_d  = sprs_pkg::S_LOCK;
                end
            end
            sprs_pkg::S_LOCK:
            begin
                if (cnt_zero)
                begin
                    wr_d   = 1'b1;
                    wdat_d = 1'b1;
                    st_d   = sprs_pkg::S_START;
                end
            end
            sprs_pkg::S_START:
            begin
                if (wr_ack)
                begin
                    wr_d   = 1'b0;
                    strm_d = 1'b1;
                    st_d   = sprs_pkg::S_STREAM;
                end
            end
            sprs_pkg::S_STREAM:
            begin
                if (power_down)
                begin
                    wr_d   = 1'b1;
                    wdat_d = 1'b0;
                    st_d   = sprs_pkg::S_STOP;
                end
            end
            sprs_pkg::S_STOP:
            begin
                if (wr_ack)
                begin
                    wr_d   = 1'b0;
                    strm_d = 1'b0;
                    st_d   = sprs_pkg::S_DRAIN;
                end
            end
            sprs_pkg::S_DRAIN:
            begin
                if (stby_s)
                begin
                    rst_d   = 1'b0;
                    clkon_d = 1'b0;
                    rails_d = {1'b0, rails_q[3:0]};
                    st_d    = sprs_pkg::S_RAILS_DN;
                end
            end
            sprs_pkg::S_RAILS_DN:
            begin
                if (rails_q == sprs_pkg::RAILS_OFF)
                begin
                    cnt_d = OFF_TIME_CYC - 1;
                    st_d  = sprs_pkg::S_COOL;
                end
                else
                begin
                    rails_d = {1'b0, rails_q[4:1]};
                end
            end
            sprs_pkg::S_COOL:
            begin
                if (cnt_zero)
                begin
                    st_d = sprs_pkg::S_OFF;
                end
            end
            default:
            begin
                st_d = sprs_pkg::S_OFF;
            end
        endcase
        busy_d = (st_d != sprs_pkg::S_OFF) && (st_d != sprs_pkg::S_STREAM);
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q    <= sprs_pkg::S_OFF;
            cnt_q   <= 32'h0;
            rails_q <= sprs_pkg::RAILS_OFF;
            rst_q   <= 1'b0;
            go_q    <= 1'b0;
            wr_q    <= 1'b0;
            wdat_q  <= 1'b0;
            strm_q  <= 1'b0;
            clkon_q <= 1'b0;
            busy_q  <= 1'b0;
        end
        else
        begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            rails_q <= rails_d;
            rst_q   <= rst_d;
            go_q    <= go_d;
            wr_q    <= wr_d;
            wdat_q  <= wdat_d;
            strm_q  <= strm_d;
            clkon_q <= clkon_d;
            busy_q  <= busy_d;
        end
    end

    assign rails_en              = rails_q;
    assign external_master_clock = mclk_q;
    assign sensor_reset_b        = rst_q;
    assign config_go             = go_q;
    assign wr_req                = wr_q;
    assign wr_addr               = sprs_pkg::CTRL_REG_ADDR;
    assign wr_data               = {13'h0, wdat_q, 2'h0};
    assign streaming             = strm_q;
    assign busy                  = busy_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_pll_first: assert property (@(posedge clk) disable iff (!rst_b)
        (|rails_q[4:1]) |-> rails_q[0])
        else $error("pll rail off while another rail on");
    a_rail_step: assert property (@(posedge clk) disable iff (!rst_b)
        (st_q == sprs_pkg::S_RAILS_UP && rails_q != $past(rails_q))
        |-> cnt_q == RAIL_STEP_CYC - 1)
        else $error("rail step not spaced");
    a_clk_rails: assert property (@(posedge clk) disable iff (!rst_b)
        (clkon_q || mclk_q) |-> rails_q == sprs_pkg::RAILS_ALL)
        else $error("clock running without all rails");
    a_reset_hold: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(rst_q) |-> $past(st_q) == sprs_pkg::S_RESET && $past(cnt_zero))
        else $error("reset released early");
    a_init_wait: assert property (@(posedge clk) disable iff (!rst_b)
        go_q |-> $past(st_q) == sprs_pkg::S_INIT && rst_q)
        else $error("configure before init wait");
    a_lock_wait: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(wr_q) && wdat_q |-> $past(st_q) == sprs_pkg::S_LOCK)
        else $error("stream start before pll lock");
    a_stop_first: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(rails_q[4]) |-> !strm_q && !rst_q)
        else $error("rails removed while streaming");
    a_rail_order: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(rails_q[0]) |-> rails_q == sprs_pkg::RAILS_OFF)
        else $error("pll rail removed before others");
    a_off_time: assert property (@(posedge clk) disable iff (!rst_b)
        (st_q == sprs_pkg::S_COOL && !cnt_zero) |-> rails_q == sprs_pkg::RAILS_OFF)
        else $error("power during off time");
    c_stream: cover property (@(posedge clk) disable iff (!rst_b) $rose(strm_q));
    c_stop: cover property (@(posedge clk) disable iff (!rst_b) $fell(strm_q));
    c_cool: cover property (@(posedge clk) disable iff (!rst_b)
        st_q == sprs_pkg::S_COOL ##1 st_q == sprs_pkg::S_OFF);
endmodule : sprs_sequencer
`default_nettype wire

/* File: tb/sprs_sensor_model.sv */
// behavioural sensor plus outside config master seen by the sequencer
// assumes same clock as the sequencer; viol latches rail order, clock without rails, early config or unpowered streaming
`timescale 1ns/1ps
`default_nettype none
module sprs_sensor_model #(
    parameter int unsigned INIT_EXTCLKS = 3,
    parameter int unsigned ROW_LEN      = 6
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [4:0]  rails_en,
    input  wire logic        external_master_clock,
    input  wire logic        sensor_reset_b,
    input  wire logic        config_go,
    input  wire logic        wr_req,
    input  wire logic [15:0] wr_addr,
    input  wire logic [15:0] wr_data,
    input  wire logic [3:0]  ack_wait,
    output logic             wr_ack,
    output logic             config_done,
    output logic             standby_reached,
    output logic             dout_oe,
    output logic             sensor_streaming,
    output logic             viol
);
    logic [3:0]  ack_cnt_q;
    logic        acked_q;
    logic        mclk_q;
    logic        stream_q;
    logic [31:0] ext_cnt_q;
    logic [3:0]  row_q;
    logic [2:0]  cfg_q;
    assign dout_oe = sensor_reset_b && (rails_en == 5'h1f);
    assign sensor_streaming = stream_q;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {wr_ack, acked_q, ack_cnt_q, mclk_q, stream_q, ext_cnt_q} <= '0;
            {row_q, cfg_q, config_done, standby_reached, viol} <= '0;
        end
        else
        begin
            wr_ack <= 1'b0;
            mclk_q <= external_master_clock;
            row_q <= (row_q == 4'(ROW_LEN - 1)) ? 4'h0 : row_q + 4'h1;
            if (!wr_req)
                {acked_q, ack_cnt_q} <= '0;
            else if (!acked_q && ack_cnt_q == ack_wait)
            begin
                wr_ack <= 1'b1;
                acked_q <= 1'b1;
                if (wr_addr == 16'h301a)
                    stream_q <= wr_data[2];
            end
            else if (!acked_q)
                ack_cnt_q <= ack_cnt_q + 4'h1;
            if (!sensor_reset_b)
                {ext_cnt_q, cfg_q, config_done, stream_q, standby_reached} <= '0;
            else
            begin
                if (external_master_clock && !mclk_q)
                    ext_cnt_q <= ext_cnt_q + 1;
                // standby only at a row boundary
                if (stream_q)
                    standby_reached <= 1'b0;
                else if (row_q == 4'(ROW_LEN - 1))
                    standby_reached <= 1'b1;
                if (config_go)
                    cfg_q <= 3'h1;
                else if (cfg_q == 3'h3)
                    config_done <= 1'b1;
                else if (cfg_q != 3'h0)
                    cfg_q <= cfg_q + 3'h1;
            end
            if (rails_en[4:1] != 4'h0 && !rails_en[0])
                viol <= 1'b1;
            if (external_master_clock && rails_en != 5'h1f)
                viol <= 1'b1;
            if (config_go && ext_cnt_q < INIT_EXTCLKS)
                viol <= 1'b1;
            if (stream_q && rails_en != 5'h1f)
                viol <= 1'b1;
        end
    end
endmodule : sprs_sensor_model
`default_nettype wire

/* File: tb/sprs_sequencer_tb.sv */
// self-checking bench for the sensor power and reset sequencer
// assumes sprs_pkg compiled first; short counts set by parameter
`timescale 1ns/1ps
`default_nettype none
module sprs_sequencer_tb;
    localparam int unsigned STEP = 4;
    localparam int unsigned HRST = 8;
    localparam int unsigned INIT = 16;
    localparam int unsigned LOCK = 8;
    localparam int unsigned COOL = 16;
    logic clk = 0, rst_b = 0, power_up = 0, power_down = 0;
    logic wr_ack, config_done, standby_reached, dout_oe, s_strm, viol;
    logic [3:0] ack_wait = 4'h0;
    logic [4:0] rails_en;
    logic mclk, sensor_reset_b, config_go, wr_req, streaming, busy;
    logic [15:0] wr_addr, wr_data;
    int num_errors = 0, checks_done = 0, cyc = 0;
    always #5 clk = ~clk;
    sprs_sequencer #(.RAIL_STEP_CYC(STEP), .HARD_RESET_CYC(HRST), .INIT_CYC(INIT),
        .PLL_LOCK_CYC(LOCK), .OFF_TIME_CYC(COOL)) u_sprs_sequencer (.clk(clk),
        .rst_b(rst_b), .power_up(power_up), .power_down(power_down),
        .config_done(config_done), .standby_reached(standby_reached), .wr_ack(wr_ack),
        .rails_en(rails_en), .external_master_clock(mclk), .sensor_reset_b(sensor_reset_b),
        .config_go(config_go), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
        .streaming(streaming), .busy(busy));
    sprs_sensor_model u_sprs_sensor_model (.clk(clk), .rst_b(rst_b), .rails_en(rails_en),
        .external_master_clock(mclk), .sensor_reset_b(sensor_reset_b),
        .config_go(config_go), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
        .ack_wait(ack_wait), .wr_ack(wr_ack), .config_done(config_done),
        .standby_reached(standby_reached), .dout_oe(dout_oe), .sensor_streaming(s_strm),
        .viol(viol));
    task automatic finish_test();
        if (num_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    // counts falling edges until cond holds or lim runs out
    task automatic wait_on(ref logic s, input logic v, input int lim, output int n);
        n = 0;
        while (s !== v && n < lim)
        begin
            tick(1);
            n++;
        end
    endtask : wait_on
    // counts falling edges until the rail vector leaves old or lim runs out
    task automatic wait_rails(input logic [4:0] old, input int lim, output int n);
        n = 0;
        while (rails_en === old && n < lim)
        begin
            tick(1);
            n++;
        end
    endtask : wait_rails
    task automatic t_power_up(input logic [3:0] aw);
        int n;
        logic [4:0] e;
        ack_wait = aw;
        power_up = 1;
        tick(1);
        power_up = 0;
        wait_rails(5'h00, 4, n);
        chk("rails_first", 5'h01, rails_en);
        for (int i = 1; i < 5; i++)
        begin
            e = 5'h1f >> (4 - i);
            wait_rails(5'h1f >> (5 - i), 2 * STEP, n);
            chk("rails_gap", STEP, n);
            chk("rails_val", e, rails_en);
        end
        wait_on(mclk, 1, 4 * STEP, n);
        chk("dout_hiz", 0, dout_oe);
        wait_on(sensor_reset_b, 1, 4 * HRST, n);
        chk("hard_reset_min", 1, n >= HRST);
        wait_on(config_go, 1, 4 * INIT, n);
        chk("init_wait", 1, n >= INIT);
        wait_on(config_done, 1, 8, n);
        wait_on(wr_req, 1, 4 * LOCK, n);
        chk("lock_wait", 1, n >= LOCK);
        chk("wr_addr", 16'h301a, wr_addr);
        chk("wr_on_data", 16'h0004, wr_data);
        wait_on(streaming, 1, 20, n);
        chk("stream_on", 2'b10, {s_strm, busy});
    endtask : t_power_up
    task automatic t_refuse();
        int n;
        power_down = 1;
        tick(1);
        power_down = 0;
        tick(4);
        chk("off_ignore_down", 6'h00, {busy, rails_en});
        t_power_up(4'h0);
        power_up = 1;
        tick(1);
        power_up = 0;
        tick(STEP + 2);
        chk("stream_ignore_up", 7'h5f, {streaming, busy, rails_en});
    endtask : t_refuse
    task automatic t_power_down();
        int n;
        power_down = 1;
        tick(1);
        power_down = 0;
        wait_on(wr_req, 1, 4, n);
        chk("wr_off_data", 16'h0000, wr_data);
        wait_on(s_strm, 0, 20, n);
        while (standby_reached !== 1'b1 && n < 40)
        begin
            chk("rails_hold", 5'h1f, rails_en);
            tick(1);
            n++;
        end
        for (int i = 1; i < 6; i++)
        begin
            wait_rails(5'h1f >> (i - 1), 6, n);
            chk("rails_down", 5'h1f >> i, rails_en);
        end
        chk("reset_low", 0, sensor_reset_b);
        // let the cool-down state begin before asking again
        tick(1);
        power_up = 1;
        tick(1);
        power_up = 0;
        tick(COOL - 4);
        chk("cool_refuse", 6'h20, {busy, rails_en});
        wait_on(busy, 0, COOL + 4, n);
        chk("cool_done", 0, busy);
    endtask : t_power_down
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            num_errors++;
            finish_test();
        end
    end
    initial
    begin
        tick(6);
        rst_b = 1;
        tick(1);
        t_refuse();
        t_power_down();
        t_power_up(4'h5);
        t_power_down();
        chk("model_viol", 0, viol);
        finish_test();
    end
endmodule : sprs_sequencer_tb
`default_nettype wire
